// *** spse_pkg.sv ***
package spse_pkg;

  // Register byte offsets and bus response codes
  localparam logic [7:0] REG_CONTROL = 8'h00;
  localparam logic [7:0] REG_BUFFER = 8'h04;
  localparam logic [7:0] REG_RATE = 8'h08;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Serial modes
  localparam logic [1:0] MODE_SHIFT = 2'h0;
  localparam logic [1:0] MODE_UART8 = 2'h1;
  localparam logic [1:0] MODE_UART9_FIXED = 2'h2;
  localparam logic [1:0] MODE_UART9_VAR = 2'h3;

  // Control and rate register fields
  localparam int CTL_MODE_LO = 6;
  localparam int CTL_FILTER = 5;
  localparam int CTL_RECV_EN = 4;
  localparam int CTL_TX_NINTH = 3;
  localparam int CTL_TX_FLAG = 1;
  localparam int CTL_RX_FLAG = 0;
  localparam int RATE_DOUBLE = 0;

  // Machine cycle states, S1 is zero
  localparam logic [2:0] MC_S1 = 3'h0;
  localparam logic [2:0] MC_S3 = 3'h2;
  localparam logic [2:0] MC_S5 = 3'h4;
  localparam logic [2:0] MC_S6 = 3'h5;

  // Divide-by-16 counter points
  localparam logic [3:0] DIV_LAST = 4'hf;
  localparam logic [3:0] SAMPLE_FIRST = 4'h6;
  localparam logic [3:0] SAMPLE_LAST = 4'h8;

  // Shift register preloads and markers
  localparam logic [8:0] RX_SHIFT_INIT = 9'h0ff;
  localparam logic [8:0] RX_UART_INIT = 9'h1ff;
  localparam logic [7:0] TX_LAST_MARK = 8'h01;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_WAIT = 3'b010,
    TX_SEND = 3'b100
  } spse_tx_type;

  typedef enum logic [3:0] {
    RX_IDLE = 4'b0001,
    RX_ARM = 4'b0010,
    RX_SHIFT = 4'b0100,
    RX_TAIL = 4'b1000
  } spse_rx_type;

  typedef struct packed {
    logic [2:0] mc;
    logic [1:0] mode;
    logic filt;
    logic ren;
    logic tb8;
    logic rb8;
    logic ti;
    logic ri;
    logic [7:0] rxBuf;
    logic rateDouble;
    logic preTog;
    logic [3:0] txDiv;
    spse_tx_type txSt;
    logic [8:0] txShift;
    logic txData;
    logic txFirst;
    logic txLast0;
    spse_rx_type rxSt;
    logic [3:0] rxDiv;
    logic [8:0] rxShift;
    logic rxPrev;
    logic [1:0] votes;
    logic rxFirst;
    logic rxLast0;
    logic sample0;
    logic awHeld;
    logic [31:0] awAddr;
    logic wHeld;
    logic [7:0] wData;
    logic wLane0;
    logic bValid;
    logic [1:0] bResp;
    logic rValid;
    logic [7:0] rData;
    logic [1:0] rResp;
  } spse_state_type;

endpackage

// *** spse_remote.sv ***
`timescale 1ns/100ps
`default_nettype none
module spse_remote (
  // Clock
  input wire logic core_clk,
  // Pin levels seen on the line
  input wire logic txLine,
  input wire logic rxLine,
  // Drive toward the rx pin, pulled up when released
  output logic rxDrive
);
  initial rxDrive = 1'b1;

  // frame out, start first
  // A spike flips one clock of one bit to probe the vote
  task automatic sendUart(input logic [10:0] bits, input int bitClk, input int spike);
    for (int i = 0; i < 11; i++) begin
      for (int c = 0; c < bitClk; c++) begin
        @(posedge core_clk);
        rxDrive <= (i == spike && c == 7) ? ~bits[i] : bits[i];
      end
    end
    @(posedge core_clk);
    rxDrive <= 1'b1;
    repeat (bitClk) @(posedge core_clk);
  endtask

  task automatic catchUart(input int n, input int bitClk, output logic [31:0] bits);
    bits = '0;
    @(negedge txLine);
    repeat (bitClk / 2) @(posedge core_clk);
    for (int i = 0; i < n; i++) begin
      bits[i] = txLine;
      repeat (bitClk) @(posedge core_clk);
    end
  endtask

  // Shift mode: data taken on the rising shift clock
  task automatic catchShift(output logic [31:0] bits);
    bits = '0;
    for (int i = 0; i < 8; i++) begin
      @(posedge txLine);
      bits[i] = rxLine;
    end
  endtask

  // Shift mode: next bit after each falling shift clock
  task automatic sendShift(input logic [7:0] dat);
    for (int i = 0; i < 8; i++) begin
      @(negedge txLine);
      rxDrive <= dat[i];
    end
    @(posedge txLine);
    rxDrive <= 1'b1;
  endtask
endmodule
`default_nettype wire

// *** spse_serial_port.sv ***
// How it works
// - Mode 0 shifts eight bits, clock on tx.
// - Buffer write marks ninth bit, sends next cycle.
// - Shift clock low S3-S5, shift at S6.
// - Marker beside MSB ends send, sets flag.
// - Mode 0 receive preloads register, then enables.
// - Receive shifts at S6 with S5 sample.
// - Zero at far end loads buffer, sets flag.
// - Eight-bit frame: start, data, stop into ninth.
// - UART send starts after next counter rollover.
// - Start bit, then data, then first shift.
// - Eight-bit send ends at tenth rollover.
// - Falling edge resets counter, preloads all ones.
// - Majority of samples seven, eight, nine.
// - Bad start bit returns to edge hunting.
// - Start at far end triggers last shift.
// - Accept only if flag clear and, with filter set, stop valid.
// - Nine-bit receiver rehunts one bit later.
// - Nine-bit frame carries programmable ninth bit.
// - Fixed rate sixteenth or thirty-second, else timer.
// - First nine-bit shift inserts stop bit.
// - Nine-bit send ends at eleventh rollover.
// - Accept only if flag clear and, with filter set, ninth valid.
`timescale 1ns/100ps
`default_nettype none
module spse_serial_port (
  // Clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // AXI4-Lite write channels
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Unused type guard, then the baud source for the variable-rate modes
  input wire spse_pkg::spse_tx_type unusedTypeGuard,
  input wire logic timerOverflow,
  // Serial pins
  input wire logic portPinRxAltIn,
  output logic portPinRxAltOut,
  output logic portPinRxAltOe,
  output logic portPinTxAlt
);
  import spse_pkg::*;

  spse_state_type q;
  spse_state_type d;
  logic modeShift;
  logic nineBit;
  logic tick16;
  logic txRoll;
  logic sending;
  logic recv0;
  logic shiftClk;
  logic sclkLow;
  logic wrFire;
  logic awMapped;
  logic arMapped;
  logic voteBit;
  logic [1:0] ones;
  logic [8:0] rxNext;
  logic [8:0] txNext;
  logic accept;

  // Decoded views of the current state
  assign modeShift = (q.mode == MODE_SHIFT);
  assign nineBit = q.mode[1];
  assign sending = (q.txSt == TX_SEND);
  assign recv0 = modeShift && (q.rxSt == RX_SHIFT);
  assign sclkLow = (q.mc >= MC_S3) && (q.mc <= MC_S5);
  assign shiftClk = !sclkLow;
  assign txRoll = tick16 && (q.txDiv == DIV_LAST);
  assign wrFire = q.awHeld && q.wHeld && !q.bValid;
  assign awMapped = (q.awAddr == {24'h0, REG_CONTROL}) || (q.awAddr == {24'h0, REG_BUFFER})
                    || (q.awAddr == {24'h0, REG_RATE});
  assign arMapped = (s_axi_araddr == {24'h0, REG_CONTROL})
                    || (s_axi_araddr == {24'h0, REG_BUFFER})
                    || (s_axi_araddr == {24'h0, REG_RATE});

  // 16x sample tick; halved unless the rate-double bit is set
  // rate selection
  assign tick16 = (q.mode == MODE_UART9_FIXED) ? (q.rateDouble || q.preTog)
                  : (timerOverflow && (q.rateDouble || q.preTog));

  // Bus handshakes are combinational from held flags
  assign s_axi_awready = !q.awHeld && !q.bValid;
  assign s_axi_wready = !q.wHeld && !q.bValid;
  assign s_axi_bvalid = q.bValid;
  assign s_axi_bresp = q.bResp;
  assign s_axi_arready = !q.rValid;
  assign s_axi_rvalid = q.rValid;
  assign s_axi_rdata = {24'h0, q.rData};
  assign s_axi_rresp = q.rResp;

  // Pin drive: mode 0 uses rx as data and tx as shift clock
  // shift-register pin use
  assign portPinRxAltOe = modeShift && sending;
  assign portPinRxAltOut = q.txShift[0];
  assign portPinTxAlt = modeShift ? ((sending || recv0) ? shiftClk : 1'b1)
                        : (sending ? (q.txData ? q.txShift[0] : 1'b0) : 1'b1);

  // Majority vote and next receive shift value
  // two of three samples
  assign ones = q.votes + {1'b0, portPinRxAltIn};
  assign voteBit = ones[1];
  assign rxNext = modeShift ? {q.sample0, q.rxShift[8:1]} : {voteBit, q.rxShift[8:1]};
  assign accept = !q.ri && (!q.filt || rxNext[8]);
  // stop bit enters on first nine-bit shift
  assign txNext = {nineBit && q.txFirst, q.txShift[8:1]};

  // Next-state logic for bus, transmitter and receiver
  always_comb begin
    d = q;
    d.mc = (q.mc == MC_S6) ? MC_S1 : q.mc + 3'h1;
    if (q.mode == MODE_UART9_FIXED || timerOverflow) begin
      d.preTog = !q.preTog;
    end
    if (tick16) begin
      d.txDiv = q.txDiv + 4'h1;
    end
    // Write address and data taken in either order
    if (s_axi_awvalid && s_axi_awready) begin
      d.awHeld = 1'b1;
      d.awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.wHeld = 1'b1;
      d.wData = s_axi_wdata[7:0];
      d.wLane0 = s_axi_wstrb[0];
    end
    if (q.bValid && s_axi_bready) begin
      d.bValid = 1'b0;
    end
    if (wrFire) begin
      d.awHeld = 1'b0;
      d.wHeld = 1'b0;
      d.bValid = 1'b1;
      d.bResp = awMapped ? RESP_OKAY : RESP_SLVERR;
      if (q.wLane0 && q.awAddr == {24'h0, REG_CONTROL}) begin
        d.mode = q.wData[CTL_MODE_LO+1:CTL_MODE_LO];
        d.filt = q.wData[CTL_FILTER];
        d.ren = q.wData[CTL_RECV_EN];
        d.tb8 = q.wData[CTL_TX_NINTH];
        d.ti = q.ti && q.wData[CTL_TX_FLAG];
        d.ri = q.ri && q.wData[CTL_RX_FLAG];
      end
      if (q.wLane0 && q.awAddr == {24'h0, REG_RATE}) begin
        d.rateDouble = q.wData[RATE_DOUBLE];
      end
      // Buffer writes while busy are dropped so a frame is never torn
      if (q.wLane0 && q.awAddr == {24'h0, REG_BUFFER} && q.txSt == TX_IDLE) begin
        // ninth position set in 8-bit mode
        d.txShift = {nineBit ? q.tb8 : 1'b1, q.wData};
        d.txSt = TX_WAIT;
        d.txFirst = 1'b1;
        d.txData = 1'b0;
      end
    end
    // Read path answers in one cycle
    if (q.rValid && s_axi_rready) begin
      d.rValid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rValid = 1'b1;
      d.rResp = arMapped ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == {24'h0, REG_CONTROL}) begin
        d.rData = {q.mode, q.filt, q.ren, q.tb8, q.rb8, q.ti, q.ri};
      end else if (s_axi_araddr == {24'h0, REG_BUFFER}) begin
        // reads see only the receive buffer
        d.rData = q.rxBuf;
      end else if (s_axi_araddr == {24'h0, REG_RATE}) begin
        d.rData = {5'h0, q.rxSt != RX_IDLE, q.txSt != TX_IDLE, q.rateDouble};
      end else begin
        d.rData = 8'h0;
      end
    end
    // Transmitter
    case (q.txSt)
      TX_IDLE: begin
        d.txLast0 = 1'b0;
      end
      TX_WAIT: begin
        if (modeShift && q.mc == MC_S6) begin
          d.txSt = TX_SEND;
        end
        if (!modeShift && txRoll) begin
          d.txSt = TX_SEND;
        end
      end
      TX_SEND: begin
        if (modeShift) begin
          if (q.mc == MC_S6 && !q.txLast0) begin
            d.txShift = {1'b0, q.txShift[8:1]};
            d.txLast0 = (q.txShift[8:1] == TX_LAST_MARK);
          end
          if (q.mc == MC_S1 && q.txLast0) begin
            d.txSt = TX_IDLE;
            d.ti = 1'b1;
          end
        end else if (txRoll) begin
          if (!q.txData) begin
            d.txData = 1'b1;
          end else begin
            d.txShift = txNext;
            d.txFirst = 1'b0;
            if (!q.txFirst && q.txShift[8:1] == TX_LAST_MARK) begin
              d.txSt = TX_IDLE;
              d.ti = 1'b1;
            end
          end
        end
      end
      default: begin
        d.txSt = TX_IDLE;
      end
    endcase
    // Receiver
    if (tick16) begin
      d.rxPrev = portPinRxAltIn;
    end
    if (q.mc == MC_S5) begin
      d.sample0 = portPinRxAltIn;
    end
    case (q.rxSt)
      RX_IDLE: begin
        d.rxLast0 = 1'b0;
        // start when enabled, flag clear and transmitter idle
        if (modeShift && q.ren && !q.ri && q.txSt == TX_IDLE) begin
          d.rxSt = RX_ARM;
        end
        if (!modeShift && q.ren && tick16 && q.rxPrev && !portPinRxAltIn) begin
          d.rxSt = RX_SHIFT;
          d.rxDiv = 4'h0;
          d.rxShift = RX_UART_INIT;
          d.votes = 2'h0;
          d.rxFirst = 1'b1;
        end
      end
      RX_ARM: begin
        if (q.mc == MC_S6) begin
          d.rxShift = RX_SHIFT_INIT;
          d.rxSt = RX_SHIFT;
        end
      end
      RX_SHIFT: begin
        if (modeShift) begin
          // shift at S6 with S5 sample
          if (q.mc == MC_S6 && !q.rxLast0) begin
            d.rxShift = rxNext;
            if (!q.rxShift[1]) begin
              d.rxLast0 = 1'b1;
              d.rxBuf = rxNext[8:1];
            end
          end
          if (q.mc == MC_S1 && q.rxLast0) begin
            d.rxSt = RX_IDLE;
            d.ri = 1'b1;
          end
        end else if (tick16) begin
          d.rxDiv = q.rxDiv + 4'h1;
          if (q.rxDiv >= SAMPLE_FIRST && q.rxDiv < SAMPLE_LAST) begin
            d.votes = ones;
          end
          if (q.rxDiv == SAMPLE_LAST) begin
            d.votes = 2'h0;
            d.rxFirst = 1'b0;
            d.rxShift = rxNext;
            if (q.rxFirst && voteBit) begin
              d.rxSt = RX_IDLE;
            end else if (!q.rxShift[0]) begin
              // start at far end, last shift
              if (accept) begin
                d.rxBuf = rxNext[7:0];
                d.rb8 = rxNext[8];
                d.ri = 1'b1;
              end
              d.rxSt = nineBit ? RX_TAIL : RX_IDLE;
            end
          end
        end
      end
      RX_TAIL: begin
        if (tick16) begin
          d.rxDiv = q.rxDiv + 4'h1;
          if (q.rxDiv == SAMPLE_LAST - 4'h1) begin
            d.rxSt = RX_IDLE;
          end
        end
      end
      default: begin
        d.rxSt = RX_IDLE;
      end
    endcase
  end

  // Single state register
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      q <= '{mc: MC_S1, mode: MODE_SHIFT, txSt: TX_IDLE, rxSt: RX_IDLE, rxPrev: 1'b1,
             rxShift: RX_UART_INIT, default: '0};
    end else begin
      q <= d;
    end
  end

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  chk_sclk_low_window: assert property (
    (modeShift && (sending || recv0) && sclkLow) |-> !portPinTxAlt)
    else $error("shift clock high during S3 to S5");
  chk_tx_shift_s6: assert property (
    (modeShift && sending && q.mc != MC_S6 && !wrFire) |=> $stable(q.txShift))
    else $error("transmit shift outside S6");
  chk_ti_at_s1: assert property (
    ($rose(q.ti) && modeShift) |-> q.mc == (MC_S1 + 3'h1))
    else $error("mode 0 transmit flag not set at S1");
  chk_rx_preload: assert property (
    $rose(recv0) |-> q.rxShift == RX_SHIFT_INIT)
    else $error("receive register not preloaded");
  chk_hunt_reset: assert property (
    ($past(q.rxSt) == RX_IDLE && q.rxSt == RX_SHIFT && !modeShift)
      |-> (q.rxDiv == 4'h0 && q.rxShift == RX_UART_INIT))
    else $error("counter or register not reset on start edge");
  chk_filter_gate: assert property (
    ($rose(q.ri) && !modeShift) |-> (!$past(q.filt) || q.rb8))
    else $error("filtered frame accepted");
  chk_send_ends: assert property (
    $fell(sending) |-> q.ti)
    else $error("send dropped without transmit flag");
  chk_start_bit: assert property (
    (!modeShift && sending && !q.txData) |-> !portPinTxAlt)
    else $error("start bit not low");
  chk_bresp_hold: assert property (
    (q.bValid && !s_axi_bready) |=> q.bValid)
    else $error("write response withdrawn");

  cov_shift_tx_done: cover property ($rose(q.ti) && modeShift);
  cov_uart_rx_accept: cover property ($rose(q.ri) && nineBit);
  cov_false_start: cover property ($past(q.rxSt) == RX_SHIFT && q.rxSt == RX_IDLE && !q.ri);

endmodule
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import spse_pkg::*;
  typedef struct packed {
    logic wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic [3:0] strb;
    logic [1:0] resp;
    logic [7:0] rdat;
  } spse_row_type;
  typedef struct packed {
    logic [7:0] ctl;
    logic [7:0] dat;
    logic nin;
    logic [5:0] bitClk;
    logic [3:0] spike;
    logic [7:0] expCtl;
    logic [7:0] expBuf;
  } spse_rxrow_type;
  logic core_clk, sys_rst, awValid, awReady, wValid, wReady, bValid, bReady;
  logic arValid, arReady, rValid, rReady, rxOut, rxOe, txPin, rxDrive;
  logic timerOverflow = 1'b0;
  logic [31:0] awAddr, wData, arAddr, rData, d, cap;
  logic [3:0] wStrb;
  logic [1:0] bResp, rResp, r;
  logic [7:0] txb [2] = '{8'ha5, 8'h5a};
  int nMismatch = 0;
  int totalChecks = 0;
  // Rx line has a pull-up; whoever enables drives it
  wire logic rxWire = rxOe ? rxOut : rxDrive;
  spse_row_type rows [10] = '{
    '{1'b0, REG_CONTROL, 8'h00, 4'h1, RESP_OKAY, 8'h00},
    '{1'b0, REG_RATE, 8'h00, 4'h1, RESP_OKAY, 8'h00},
    '{1'b1, REG_RATE, 8'h01, 4'h1, RESP_OKAY, 8'h00},
    '{1'b0, REG_RATE, 8'h00, 4'h1, RESP_OKAY, 8'h01},
    '{1'b1, REG_CONTROL, 8'h8f, 4'h1, RESP_OKAY, 8'h00},
    '{1'b0, REG_CONTROL, 8'h00, 4'h1, RESP_OKAY, 8'h88},
    '{1'b1, REG_CONTROL, 8'hc0, 4'h0, RESP_OKAY, 8'h00},
    '{1'b0, REG_CONTROL, 8'h00, 4'h1, RESP_OKAY, 8'h88},
    '{1'b0, 8'h0c, 8'h00, 4'h1, RESP_SLVERR, 8'h00},
    '{1'b1, 8'h0c, 8'h00, 4'h1, RESP_SLVERR, 8'h00}
  };
  // Last row runs the timer-paced nine-bit mode
  spse_rxrow_type rxRows [8] = '{
    '{8'h90, 8'h3c, 1'b1, 6'h10, 4'hf, 8'h95, 8'h3c},
    '{8'h91, 8'h77, 1'b1, 6'h10, 4'hf, 8'h95, 8'h3c},
    '{8'hb0, 8'h55, 1'b0, 6'h10, 4'h3, 8'hb4, 8'h3c},
    '{8'hb0, 8'h55, 1'b1, 6'h10, 4'h2, 8'hb5, 8'h55},
    '{8'h90, 8'ha6, 1'b0, 6'h10, 4'hf, 8'h91, 8'ha6},
    '{8'h50, 8'h5a, 1'b1, 6'h20, 4'h5, 8'h55, 8'h5a},
    '{8'h70, 8'h33, 1'b0, 6'h20, 4'hf, 8'h74, 8'h5a},
    '{8'hd0, 8'h81, 1'b0, 6'h20, 4'hf, 8'hd1, 8'h81}
  };

  spse_serial_port dut_u (
    .core_clk(core_clk), .sys_rst(sys_rst),
    .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
    .s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
    .s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
    .s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
    .s_axi_rvalid(rValid), .s_axi_rready(rReady),
    .unusedTypeGuard(spse_tx_type'(3'h0)), .timerOverflow(timerOverflow),
    .portPinRxAltIn(rxWire), .portPinRxAltOut(rxOut), .portPinRxAltOe(rxOe),
    .portPinTxAlt(txPin)
  );
  spse_remote remote_u (
    .core_clk(core_clk), .txLine(txPin), .rxLine(rxWire), .rxDrive(rxDrive)
  );

  // 10 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  // Overflow every second clock gives a 32-clock bit in the timer modes
  always @(posedge core_clk) timerOverflow <= ~timerOverflow;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nMismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  // Address and data offered together; one edge gap after the answer
  task automatic axWr(input logic [7:0] a, input logic [31:0] dt, input logic [3:0] s,
    output logic [1:0] rsp);
    awAddr <= {24'h0, a};
    wData <= dt;
    wStrb <= s;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (awReady) awValid <= 1'b0;
      if (wReady) wValid <= 1'b0;
    end while (!bValid);
    rsp = bResp;
    bReady <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic axRd(input logic [7:0] a, output logic [31:0] dt, output logic [1:0] rsp);
    arAddr <= {24'h0, a};
    arValid <= 1'b1;
    rReady <= 1'b1;
    do begin
      @(posedge core_clk);
      if (arReady) arValid <= 1'b0;
    end while (!rValid);
    dt = rData;
    rsp = rResp;
    rReady <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic conclude;
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Whole run is a few thousand clocks
  initial begin
    repeat (30000) @(posedge core_clk);
    nMismatch++;
    conclude;
  end

  initial begin
    {awValid, wValid, bReady, arValid, rReady} = 5'h0;
    {awAddr, wData, arAddr} = '0;
    wStrb = 4'h0;
    sys_rst = 1'b1;
    repeat (20) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    // Register map, reset values, software cannot set flags
    foreach (rows[k]) begin
      if (rows[k].wr) axWr(rows[k].addr, {24'h0, rows[k].data}, rows[k].strb, r);
      else begin
        axRd(rows[k].addr, d, r);
        chk(d, {24'h0, rows[k].rdat});
      end
      chk({30'h0, r}, {30'h0, rows[k].resp});
    end
    // Nine-bit sends; the second buffer write hits a busy sender
    for (int i = 0; i < 2; i++) begin
      axWr(REG_CONTROL, {24'h0, 4'h8, i[0], 3'h0}, 4'h1, r);
      fork
        begin
          axWr(REG_BUFFER, {24'h0, txb[i]}, 4'h1, r);
          axWr(REG_BUFFER, 32'h11, 4'h1, r);
        end
        remote_u.catchUart(11, 16, cap);
      join
      chk(cap, {21'h0, 1'b1, i[0], txb[i], 1'b0});
      repeat (32) @(posedge core_clk);
      axRd(REG_CONTROL, d, r);
      chk(d, {24'h0, 4'h8, i[0], 3'h2});
    end
    // Eight-bit send on the timer rate
    axWr(REG_CONTROL, 32'h40, 4'h1, r);
    fork
      axWr(REG_BUFFER, 32'h96, 4'h1, r);
      remote_u.catchUart(10, 32, cap);
    join
    chk(cap, 32'h32c);
    repeat (64) @(posedge core_clk);
    axRd(REG_CONTROL, d, r);
    chk(d, 32'h42);
    // Receive: held flag, filter, spikes, both frame lengths
    foreach (rxRows[k]) begin
      axWr(REG_CONTROL, {24'h0, rxRows[k].ctl}, 4'h1, r);
      remote_u.sendUart({1'b1, rxRows[k].nin, rxRows[k].dat, 1'b0},
        int'(rxRows[k].bitClk), int'(rxRows[k].spike));
      axRd(REG_CONTROL, d, r);
      chk(d, {24'h0, rxRows[k].expCtl});
      axRd(REG_BUFFER, d, r);
      chk(d, {24'h0, rxRows[k].expBuf});
    end
    // Short low pulse, then a real frame
    axWr(REG_CONTROL, 32'h90, 4'h1, r);
    remote_u.sendUart(11'h7fe, 4, 15);
    remote_u.sendUart({2'b11, 8'hc7, 1'b0}, 16, 15);
    axRd(REG_CONTROL, d, r);
    chk(d, 32'h95);
    axRd(REG_BUFFER, d, r);
    chk(d, 32'hc7);
    // Shift mode send; received byte must survive it
    axWr(REG_CONTROL, 32'h00, 4'h1, r);
    fork
      axWr(REG_BUFFER, 32'hc3, 4'h1, r);
      remote_u.catchShift(cap);
    join
    chk(cap, 32'hc3);
    repeat (12) @(posedge core_clk);
    axRd(REG_CONTROL, d, r);
    chk(d, 32'h06);
    axRd(REG_BUFFER, d, r);
    chk(d, 32'hc7);
    // Shift mode receive after enable with flag clear
    fork
      axWr(REG_CONTROL, 32'h10, 4'h1, r);
      remote_u.sendShift(8'h69);
    join
    repeat (12) @(posedge core_clk);
    axRd(REG_CONTROL, d, r);
    chk(d, 32'h15);
    axRd(REG_BUFFER, d, r);
    chk(d, 32'h69);
    // Reset in mid-run clears control
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    @(posedge core_clk);
    axRd(REG_CONTROL, d, r);
    chk(d, 32'h00);
    conclude;
  end
endmodule
`default_nettype wire
